/* rtl/adv_store.sv */
// module: local advertisement register with strap-loaded defaults
`timescale 1ns/1ps
`default_nettype none
module adv_store (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic full_duplex_strap_pin,
  input wire logic speed_config_strap_pin,
  adv_word_if.owner aw
);
  import anreg_pkg::*;
  logic [15:0] adv_r;
  logic [15:0] adv_nxt;

  // reset loads straps, writes touch only writable bits
  always_comb begin
    adv_nxt = adv_r;
    if (srst) begin
      adv_nxt = '0;
      adv_nxt[SEL_LSB +: 5] = SEL_ETHERNET;
      adv_nxt[BIT_10FD] = full_duplex_strap_pin & speed_config_strap_pin;
      adv_nxt[BIT_10] = speed_config_strap_pin;
    end else if (aw.wr) begin
      adv_nxt = aw.wdata & ADV_WMASK;
    end
  end

  // strap capture is a clocked load, not an async reset value
  always_ff @(posedge clk) begin
    if (ce) adv_r <= adv_nxt;
  end

  // reserved bits 15, 14, 12, 11 never leave the mask
  assign aw.word = {adv_r[15:13], 2'b00, adv_r[10:0]};

  property p_strap_load;
    @(posedge clk) (srst && ce) |=> (adv_r[BIT_10FD] == $past(full_duplex_strap_pin
      & speed_config_strap_pin)) && (adv_r[BIT_10] == $past(speed_config_strap_pin));
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap defaults wrong");

  property p_sel_reset;
    @(posedge clk) (srst && ce) |=> adv_r[4:0] == SEL_ETHERNET && adv_r[15:11] == 5'h00;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("selector reset wrong");

  property p_rsvd_zero;
    @(posedge clk) disable iff (srst) aw.word[15] == 1'b0 && aw.word[12:11] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");
endmodule // adv_store
`default_nettype wire

/* rtl/adv_word_if.sv */
// interface: local advertisement word and its write strobe between modules
`timescale 1ns/1ps
`default_nettype none
interface adv_word_if;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] word;
  modport owner (input wr, input wdata, output word);
  modport user (output wr, output wdata, input word);
endinterface
`default_nettype wire

/* rtl/anreg_pkg.sv */
// package: register map, field layout and reset values of the ability registers
`default_nettype none
package anreg_pkg;
  localparam logic [4:0] REG_ID1 = 5'h02;
  localparam logic [4:0] REG_ID2 = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  localparam int BIT_NP = 15;
  localparam int BIT_ACK = 14;
  localparam int BIT_RF = 13;
  localparam int BIT_PAUSE = 10;
  localparam int BIT_T4 = 9;
  localparam int BIT_TXFD = 8;
  localparam int BIT_TX = 7;
  localparam int BIT_10FD = 6;
  localparam int BIT_10 = 5;
  localparam int SEL_LSB = 0;
  localparam logic [4:0] SEL_ETHERNET = 5'h01;
  localparam logic [4:0] SEL_ISLAN = 5'h02;
  localparam logic [4:0] SEL_RSVD_LO = 5'h00;
  localparam logic [4:0] SEL_RSVD_HI = 5'h1F;
  // writable bits of the advertisement word: 13, 10..0
  localparam logic [15:0] ADV_WMASK = 16'h27FF;
  // link code word field order matches the partner register
  localparam logic [15:0] LPA_RESET = 16'h0000;
  // identifier values are arbitrary neutral codes
  localparam logic [23:0] ORG_ID = 24'h123456;
  localparam logic [5:0] MODEL_NUM = 6'h05;
  localparam logic [3:0] REV_NUM = 4'h1;
endpackage
`default_nettype wire

/* rtl/autoneg_ability_registers.sv */
// module: auto-negotiation ability registers with identifier read-back
// Functional notes
// - software-written remote fault bit, reset zero, advertised in outgoing code word.
// - writable pause bit, reset zero, advertises full-duplex pause.
// - four-pair 100 Mb ability bit writable though unsupported; reset zero.
// - four writable ability bits for 100/10 Mb full and half duplex.
// - at reset, 10 Mb full-duplex bit is duplex strap AND speed strap.
// - at reset, 10 Mb half-duplex bit takes the speed strap level.
// - five-bit selector, reset 00001 Ethernet; 00010 means integrated services LAN.
// - read-only partner multiple-page ability bit.
// - read-only partner acknowledge bit.
// - read-only partner pause and remote fault bits as received.
// - five read-only partner technology bits as received.
// - partner five-bit selector read-only, same meanings as local.
// - first identifier register returns organization identifier bits 3 to 18.
// - second identifier holds identifier bits 19 to 24, model, revision.
`timescale 1ns/1ps
`default_nettype none
module autoneg_ability_registers (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic full_duplex_strap_pin,
  input wire logic speed_config_strap_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  output logic [15:0] tx_word,
  output logic sel_illegal
);
  import anreg_pkg::*;

  adv_word_if aw ();
  logic [15:0] lpa_r;
  logic [15:0] lpa_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic hit_r;
  logic hit_nxt;
  logic [15:0] id1_val;
  logic [15:0] id2_val;

  adv_store u_adv (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .full_duplex_strap_pin(full_duplex_strap_pin),
    .speed_config_strap_pin(speed_config_strap_pin),
    .aw(aw)
  );

  // management writes reach only the advertisement word
  assign aw.wr = reg_wr && reg_addr == REG_ADV;
  assign aw.wdata = reg_wdata;

  // the outgoing link code word carries the advertisement as held
  assign tx_word = aw.word;

  // flag a selector that must not go on the wire
  assign sel_illegal = aw.word[4:0] != SEL_ETHERNET && aw.word[4:0] != SEL_ISLAN;

  // identifier bit mapping, organization identifier numbered from 1
  assign id1_val = ORG_ID[21:6];
  assign id2_val = {ORG_ID[5:0], MODEL_NUM, REV_NUM};

  // partner word only follows received code words
  always_comb begin
    lpa_nxt = lpa_r;
    if (srst) begin
      lpa_nxt = LPA_RESET;
    end else if (rx_word_valid) begin
      lpa_nxt = rx_word;
    end
  end

  // registered read data decode
  always_comb begin
    rdata_nxt = 16'h0000;
    hit_nxt = 1'b0;
    if (!srst && reg_rd) begin
      hit_nxt = 1'b1;
      unique case (reg_addr)
        REG_ID1: rdata_nxt = id1_val;
        REG_ID2: rdata_nxt = id2_val;
        REG_ADV: rdata_nxt = aw.word;
        REG_LPA: rdata_nxt = {lpa_r[15:13], 2'b00, lpa_r[10:0]};
        default: begin
          rdata_nxt = 16'h0000;
          hit_nxt = 1'b0;
        end
      endcase
    end
  end

  // partner word register, frozen while the enable is low
  always_ff @(posedge clk) begin
    if (ce) lpa_r <= lpa_nxt;
  end

  // read data register, cleared on an enabled cycle with no read taken, held while the enable is low
  always_ff @(posedge clk) begin
    if (ce) begin
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
    end
  end

  // read answer straight from the flops
  assign reg_rdata = rdata_r;
  assign reg_hit = hit_r;

  // a management write taken into the advertisement word
  sequence s_adv_write;
    ce && !srst && reg_wr && reg_addr == REG_ADV;
  endsequence

  // a reset cycle that the enable lets through
  sequence s_reset_cycle;
    srst && ce;
  endsequence

  // a received code word taken in
  sequence s_rx_take;
    ce && !srst && rx_word_valid;
  endsequence

  // a read of the partner register
  sequence s_lpa_read;
    ce && !srst && reg_rd && reg_addr == REG_LPA;
  endsequence

  // a management write aimed at the partner register
  sequence s_lpa_write;
    ce && !srst && reg_wr && reg_addr == REG_LPA;
  endsequence

  // remote fault and pause land in the next code word
  property p_adv_fields;
    @(posedge clk) disable iff (srst) s_adv_write |=>
      tx_word[BIT_RF] == $past(reg_wdata[BIT_RF])
      && tx_word[BIT_PAUSE] == $past(reg_wdata[BIT_PAUSE]);
  endproperty
  a_adv_fields: assert property (p_adv_fields) else $error("rf or pause not stored");

  // the four-pair ability is writable although unsupported
  property p_t4_write;
    @(posedge clk) disable iff (srst) s_adv_write |=>
      tx_word[BIT_T4] == $past(reg_wdata[BIT_T4]);
  endproperty
  a_t4_write: assert property (p_t4_write) else $error("t4 bit not stored");

  // ability bits and selector follow the written word
  property p_tech_write;
    @(posedge clk) disable iff (srst) s_adv_write |=>
      tx_word[8:5] == $past(reg_wdata[8:5]) && tx_word[4:0] == $past(reg_wdata[4:0]);
  endproperty
  a_tech_write: assert property (p_tech_write) else $error("ability bits not stored");

  // pause, remote fault and four-pair bits reset clear
  property p_pause_reset;
    @(posedge clk) (srst && ce) |=> tx_word[BIT_PAUSE] == 1'b0 && tx_word[BIT_RF] == 1'b0
      && tx_word[BIT_T4] == 1'b0;
  endproperty
  a_pause_reset: assert property (p_pause_reset) else $error("adv reset nonzero");

  // a valid received word is captured whole
  property p_lpa_capture;
    @(posedge clk) disable iff (srst) (ce && rx_word_valid) |=>
      lpa_r == $past(rx_word);
  endproperty
  a_lpa_capture: assert property (p_lpa_capture) else $error("partner word not captured");

  // without a received word the partner register holds
  property p_lpa_hold;
    @(posedge clk) disable iff (srst) (ce && !rx_word_valid) |=> $stable(lpa_r);
  endproperty
  a_lpa_hold: assert property (p_lpa_hold) else $error("partner word changed");

  // partner register reads back as held, except bits 12 and 11 which read as zero
  property p_lpa_read;
    @(posedge clk) disable iff (srst) (ce && reg_rd && reg_addr == REG_LPA) |=>
      reg_rdata[15:13] == $past(lpa_r[15:13]) && reg_rdata[4:0] == $past(lpa_r[4:0])
      && reg_rdata[10:5] == $past(lpa_r[10:5]);
  endproperty
  a_lpa_read: assert property (p_lpa_read) else $error("partner read mismatch");

  // first identifier word is fixed
  property p_id_read;
    @(posedge clk) disable iff (srst) (ce && reg_rd && reg_addr == REG_ID1) |=>
      reg_rdata == ORG_ID[21:6] && reg_hit;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identifier 1 wrong");

  // second identifier word carries the low six identifier bits and revision
  property p_id2_read;
    @(posedge clk) disable iff (srst) (ce && reg_rd && reg_addr == REG_ID2) |=>
      reg_rdata[15:10] == ORG_ID[5:0] && reg_rdata[3:0] == REV_NUM;
  endproperty
  a_id2_read: assert property (p_id2_read) else $error("identifier 2 wrong");

  // the model number sits between identifier bits and revision
  property p_id2_model;
    @(posedge clk) disable iff (srst) (ce && reg_rd && reg_addr == REG_ID2) |=>
      reg_rdata[9:4] == MODEL_NUM;
  endproperty
  a_id2_model: assert property (p_id2_model) else $error("model number wrong");

  // a written pause bit goes out in the next code word
  property p_pause_write;
    @(posedge clk) disable iff (srst) s_adv_write |=>
      tx_word[BIT_PAUSE] == $past(reg_wdata[BIT_PAUSE]);
  endproperty
  a_pause_write: assert property (p_pause_write) else $error("pause bit not stored");

  // no other access, and no cycle with the enable low, moves the advertisement
  property p_tx_hold;
    @(posedge clk) disable iff (srst) !(ce && reg_wr && reg_addr == REG_ADV) |=>
      $stable(tx_word);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("advertisement moved");

  // the half-duplex ability follows the speed strap through reset
  property p_half_strap;
    @(posedge clk) s_reset_cycle |=>
      tx_word[BIT_10] == $past(speed_config_strap_pin);
  endproperty
  a_half_strap: assert property (p_half_strap) else $error("half duplex default wrong");

  // the 100 Mb abilities come out of reset clear
  property p_tech_reset;
    @(posedge clk) s_reset_cycle |=>
      tx_word[BIT_TXFD] == 1'b0 && tx_word[BIT_TX] == 1'b0;
  endproperty
  a_tech_reset: assert property (p_tech_reset) else $error("100 Mb default set");

  // reset leaves a legal selector and a quiet flag
  property p_sel_boot;
    @(posedge clk) s_reset_cycle |=>
      tx_word[4:0] == SEL_ETHERNET && !sel_illegal;
  endproperty
  a_sel_boot: assert property (p_sel_boot) else $error("boot selector wrong");

  // a reserved selector is stored but flagged
  property p_rsvd_flag;
    @(posedge clk) disable iff (srst) s_adv_write ##0
      (reg_wdata[4:0] == SEL_RSVD_LO || reg_wdata[4:0] == SEL_RSVD_HI) |=> sel_illegal;
  endproperty
  a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved selector not flagged");

  // the second defined selector is legal
  property p_islan_legal;
    @(posedge clk) disable iff (srst) s_adv_write ##0 (reg_wdata[4:0] == SEL_ISLAN) |=>
      !sel_illegal;
  endproperty
  a_islan_legal: assert property (p_islan_legal) else $error("legal selector flagged");

  // a taken word shows its multiple-page bit on the next read
  property p_lpa_np;
    @(posedge clk) disable iff (srst) s_rx_take ##1 s_lpa_read |=>
      reg_rdata[BIT_NP] == $past(rx_word[BIT_NP], 2);
  endproperty
  a_lpa_np: assert property (p_lpa_np) else $error("partner page bit wrong");

  // a taken word shows its acknowledge bit on the next read
  property p_lpa_ack;
    @(posedge clk) disable iff (srst) s_rx_take ##1 s_lpa_read |=>
      reg_rdata[BIT_ACK] == $past(rx_word[BIT_ACK], 2);
  endproperty
  a_lpa_ack: assert property (p_lpa_ack) else $error("partner acknowledge wrong");

  // partner pause and remote fault mirror the taken word
  property p_lpa_pause_rf;
    @(posedge clk) disable iff (srst) s_rx_take ##1 s_lpa_read |=>
      reg_rdata[BIT_PAUSE] == $past(rx_word[BIT_PAUSE], 2) && reg_rdata[BIT_RF] == $past(rx_word[BIT_RF], 2);
  endproperty
  a_lpa_pause_rf: assert property (p_lpa_pause_rf) else $error("partner pause or fault wrong");

  // partner technology bits mirror the taken word
  property p_lpa_tech;
    @(posedge clk) disable iff (srst) s_rx_take ##1 s_lpa_read |=>
      reg_rdata[9:5] == $past(rx_word[9:5], 2);
  endproperty
  a_lpa_tech: assert property (p_lpa_tech) else $error("partner abilities wrong");

  // partner selector mirrors the taken word
  property p_lpa_sel;
    @(posedge clk) disable iff (srst) s_rx_take ##1 s_lpa_read |=>
      reg_rdata[4:0] == $past(rx_word[4:0], 2);
  endproperty
  a_lpa_sel: assert property (p_lpa_sel) else $error("partner selector wrong");

  // a management write never reaches the partner word
  property p_lpa_no_write;
    @(posedge clk) disable iff (srst) s_lpa_write ##0 !rx_word_valid |=>
      $stable(lpa_r);
  endproperty
  a_lpa_no_write: assert property (p_lpa_no_write) else $error("partner word written");

  // reset clears the partner word
  property p_lpa_reset;
    @(posedge clk) s_reset_cycle |=>
      lpa_r == LPA_RESET;
  endproperty
  a_lpa_reset: assert property (p_lpa_reset) else $error("partner word not cleared");

  // the advertisement reads back as it goes out
  property p_adv_read;
    @(posedge clk) disable iff (srst) (ce && reg_rd && reg_addr == REG_ADV) |=>
      reg_rdata == $past(tx_word) && reg_hit;
  endproperty
  a_adv_read: assert property (p_adv_read) else $error("advertisement read wrong");

  // reserved advertisement bits read as zero
  property p_adv_rsvd_read;
    @(posedge clk) disable iff (srst) (ce && reg_rd && reg_addr == REG_ADV) |=>
      reg_rdata[15:14] == 2'b00 && reg_rdata[12:11] == 2'b00;
  endproperty
  a_adv_rsvd_read: assert property (p_adv_rsvd_read) else $error("reserved bits read set");
endmodule // autoneg_ability_registers
`default_nettype wire

/* testbench/autoneg_ability_registers_test.sv */
// testbench: register access, strap defaults and partner words
`timescale 1ns/1ps
`default_nettype none
module autoneg_ability_registers_test;
  import anreg_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, fd = 1'b1, sp = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, vld, hit, ill;
  logic [4:0] addr = 5'h00;
  logic [15:0] wd = 16'h0000, pw = 16'h0000, rdata, rxw, txw;
  logic [4:0] sels [4] = '{SEL_ETHERNET, SEL_ISLAN, SEL_RSVD_LO, SEL_RSVD_HI};
  int n_mismatch = 0, checks = 0;
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  link_partner u_lp (.clk(clk), .go(go), .word(pw), .rx_word_valid(vld), .rx_word(rxw));
  autoneg_ability_registers u_dut (.clk(clk), .srst(srst), .ce(ce),
    .full_duplex_strap_pin(fd), .speed_config_strap_pin(sp), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata), .reg_hit(hit),
    .rx_word_valid(vld), .rx_word(rxw), .tx_word(txw), .sel_illegal(ill));
  // compare and count
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    addr = a;
    wd = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  // one read strobe, data and hit checked the cycle after
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk("reg_rdata", rdata, e);
    chk("reg_hit", {15'h0000, hit}, {15'h0000, a inside {REG_ID1, REG_ID2, REG_ADV, REG_LPA}});
    @(posedge clk);
    #1;
    chk("reg_rdata_idle", rdata, 16'h0000);
  endtask
  // reset for 10 cycles with given strap levels
  task automatic rst(input logic f, input logic s);
    @(posedge clk);
    #1;
    srst = 1'b1;
    fd = f;
    sp = s;
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask
  // partner sends one code word
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    #1;
    go = 1'b1;
    pw = w;
    @(posedge clk);
    #1;
    go = 1'b0;
  endtask
  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #50000;
    n_mismatch++;
    wrap_up;
  end
  // main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      rst(i[1], i[0]);
      rd(REG_ADV, {9'h000, i[1] & i[0], i[0], SEL_ETHERNET});
      chk("tx_word", txw, {9'h000, i[1] & i[0], i[0], SEL_ETHERNET});
      rd(REG_LPA, 16'h0000);
    end
    wr(REG_ADV, 16'hFFFF);
    chk("tx_word", txw, ADV_WMASK);
    rd(REG_ADV, ADV_WMASK);
    // clock enable low must freeze the register
    ce = 1'b0;
    wr(REG_ADV, 16'h0000);
    ce = 1'b1;
    chk("tx_word", txw, ADV_WMASK);
    wr(REG_ADV, 16'h2401);
    chk("tx_word", txw, 16'h2401);
    wr(REG_ADV, 16'h0201);
    chk("tx_word", txw, 16'h0201);
    wr(REG_ADV, 16'h0181);
    chk("tx_word", txw, 16'h0181);
    for (int i = 0; i < 4; i++) begin
      wr(REG_ADV, {11'h000, sels[i]});
      chk("sel_illegal", {15'h0000, ill}, {15'h0000, i > 1});
      rd(REG_ADV, {11'h000, sels[i]});
    end
    send(16'hE7E5);
    rd(REG_LPA, 16'hE7E5);
    wr(REG_LPA, 16'h0000);
    rd(REG_LPA, 16'hE7E5);
    send(16'h1800);
    rd(REG_LPA, 16'h0000);
    rd(REG_ID1, ORG_ID[21:6]);
    rd(REG_ID2, {ORG_ID[5:0], MODEL_NUM, REV_NUM});
    rd(5'h07, 16'h0000);
    wrap_up;
  end
endmodule // autoneg_ability_registers_test
`default_nettype wire

/* testbench/link_partner.sv */
// link partner model: hands received code words to the block
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] word,
  output logic rx_word_valid,
  output logic [15:0] rx_word
);
  // one-cycle word, then an idle bus that flips every cycle
  always_ff @(posedge clk) begin
    rx_word_valid <= go;
    rx_word <= go ? word : ~rx_word;
  end
endmodule // link_partner
`default_nettype wire
